// ===== rtl/gpio_port.sv
`timescale 1ns/1ps
`include "gpio_port_params.svh"
module gpio_port
  import gpio_port_pkg::*;
#(
  parameter logic [7:0] ALT_RESET = 8'h00,
  parameter logic [7:0] PIN_CONNECTED = 8'hff,
  // Identification bytes; values arbitrary
  parameter logic [95:0] ID_BYTES = 96'h0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  input wire logic [7:0] periph_out,
  input wire logic [7:0] periph_oe,
  output logic [7:0] periph_in,
  output pad_ctrl_s pad_ctrl,
  output logic port_irq,
  output logic adc_trigger
);
  logic [7:0] dir_q, dir_d, alt_q, alt_d, data_q, data_d;
  logic [7:0] raw_q, raw_d, samp_q, samp_d, prev_q, prev_d;
  irq_cfg_s cfg_q, cfg_d;
  pad_ctrl_s pad_q, pad_d;
  phase_e ph_q, ph_d;
  logic [11:0] ofs_q, ofs_d;
  logic [31:0] rdata_q, rdata_d;
  logic irq_q, irq_d, trig_q, trig_d;
  logic [7:0] pin_out_q, pin_out_d, pin_oe_q, pin_oe_d, pin_in_q, pin_in_d;
  logic [7:0] amask, wbyte, rise, fall, cond, clr;
  logic wr, rd_take;
  logic [3:0] id_idx;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign pin_out = pin_out_q;
  assign pin_oe = pin_oe_q;
  assign periph_in = pin_in_q;
  assign pad_ctrl = pad_q;
  assign port_irq = irq_q;
  assign adc_trigger = trig_q;

  // Zero-wait slave: write applies at the data-phase edge
  assign wr = (ph_q == PH_WRITE);
  assign amask = ofs_q[9:2];
  assign wbyte = hwdata[7:0] & PIN_CONNECTED;
  // Identification words start at the first ID offset, so index from there
  assign id_idx = haddr[5:2] - 4'h4;

  always_comb begin
    ph_d = PH_IDLE;
    ofs_d = ofs_q;
    rd_take = 1'b0;
    if (hsel && hready && htrans[1]) begin
      ofs_d = haddr[11:0];
      ph_d = hwrite ? PH_WRITE : PH_READ;
      rd_take = !hwrite;
    end
  end

  // Two-stage sampling; edges from consecutive synchronised samples
  assign samp_d = pin_in;
  assign prev_d = samp_q;
  assign rise = samp_q & ~prev_q;
  assign fall = ~samp_q & prev_q;

  always_comb begin
    for (int i = 0; i < `PIN_COUNT; i++) begin
      if (cfg_q.irq_sense_select[i])
        cond[i] = cfg_q.irq_event_polarity[i] ? samp_q[i] : ~samp_q[i];
      else if (cfg_q.irq_both_edges[i])
        cond[i] = rise[i] | fall[i];
      else
        cond[i] = cfg_q.irq_event_polarity[i] ? rise[i] : fall[i];
    end
  end

  assign clr = (wr && ofs_q == `OFS_IRQ_CLEAR) ? hwdata[7:0] : 8'h00;

  always_comb begin
    dir_d = dir_q;
    alt_d = alt_q;
    cfg_d = cfg_q;
    pad_d = pad_q;
    data_d = data_q;
    // Sticky edges; a new edge wins over a clear in the same cycle
    for (int i = 0; i < `PIN_COUNT; i++) begin
      if (cfg_q.irq_sense_select[i])
        raw_d[i] = cond[i];
      else
        raw_d[i] = cond[i] | (raw_q[i] & ~clr[i]);
    end
    // Input pins track the pin; output pins hold the written value
    for (int i = 0; i < `PIN_COUNT; i++) begin
      if (!dir_q[i])
        data_d[i] = samp_q[i];
    end
    if (wr) begin
      if (ofs_q < 12'h400) begin
        data_d = (data_d & ~(amask & dir_q & PIN_CONNECTED))
               | (wbyte & amask & dir_q);
      end
      case (ofs_q)
        `OFS_DIRECTION: dir_d = wbyte;
        `OFS_IRQ_SENSE: cfg_d.irq_sense_select = wbyte;
        `OFS_IRQ_BOTH: cfg_d.irq_both_edges = wbyte;
        `OFS_IRQ_EVENT: cfg_d.irq_event_polarity = wbyte;
        `OFS_IRQ_MASK: cfg_d.irq_mask = wbyte;
        `OFS_ALT_FUNC: alt_d = wbyte;
        `OFS_DRIVE_2MA: pad_d.drive_2ma_select = wbyte;
        `OFS_DRIVE_4MA: pad_d.drive_4ma_select = wbyte;
        `OFS_DRIVE_8MA: pad_d.drive_8ma_select = wbyte;
        `OFS_OPEN_DRAIN: pad_d.open_drain_select = wbyte;
        `OFS_PULL_UP: pad_d.pull_up_select = wbyte;
        `OFS_PULL_DOWN: pad_d.pull_down_select = wbyte;
        `OFS_SLEW: pad_d.slew_rate_select = wbyte;
        `OFS_DIGITAL_EN: pad_d.digital_enable = wbyte;
        default: ;
      endcase
    end
  end

  // Read data registered from the address phase, so it stands in the data phase
  always_comb begin
    rdata_d = rdata_q;
    if (rd_take) begin
      rdata_d = 32'h0;
      if (haddr[11:0] < 12'h400) begin
        rdata_d[7:0] = data_q & haddr[9:2];
      end else begin
        case (haddr[11:0])
          `OFS_DIRECTION: rdata_d[7:0] = dir_q;
          `OFS_IRQ_SENSE: rdata_d[7:0] = cfg_q.irq_sense_select;
          `OFS_IRQ_BOTH: rdata_d[7:0] = cfg_q.irq_both_edges;
          `OFS_IRQ_EVENT: rdata_d[7:0] = cfg_q.irq_event_polarity;
          `OFS_IRQ_MASK: rdata_d[7:0] = cfg_q.irq_mask;
          `OFS_IRQ_RAW: rdata_d[7:0] = raw_q;
          `OFS_IRQ_MASKED: rdata_d[7:0] = raw_q & cfg_q.irq_mask;
          `OFS_ALT_FUNC: rdata_d[7:0] = alt_q;
          `OFS_DRIVE_2MA: rdata_d[7:0] = pad_q.drive_2ma_select;
          `OFS_DRIVE_4MA: rdata_d[7:0] = pad_q.drive_4ma_select;
          `OFS_DRIVE_8MA: rdata_d[7:0] = pad_q.drive_8ma_select;
          `OFS_OPEN_DRAIN: rdata_d[7:0] = pad_q.open_drain_select;
          `OFS_PULL_UP: rdata_d[7:0] = pad_q.pull_up_select;
          `OFS_PULL_DOWN: rdata_d[7:0] = pad_q.pull_down_select;
          `OFS_SLEW: rdata_d[7:0] = pad_q.slew_rate_select;
          `OFS_DIGITAL_EN: rdata_d[7:0] = pad_q.digital_enable;
          default: begin
            if (haddr[11:0] >= `OFS_ID_FIRST) begin
              rdata_d[7:0] = ID_BYTES[8*id_idx +: 8];
            end
          end
        endcase
      end
    end
  end

  // Pin muxing between software mode and peripheral
  always_comb begin
    for (int i = 0; i < `PIN_COUNT; i++) begin
      if (alt_d[i]) begin
        pin_out_d[i] = periph_out[i];
        pin_oe_d[i] = periph_oe[i];
      end else begin
        pin_out_d[i] = data_d[i];
        pin_oe_d[i] = dir_d[i];
      end
    end
  end
  assign pin_in_d = pin_in;
  assign irq_d = |(raw_d & cfg_d.irq_mask);
  // One-cycle pulse on a new unmasked trigger-pin condition
  assign trig_d = raw_d[`ADC_TRIGGER_BIT] & cfg_d.irq_mask[`ADC_TRIGGER_BIT]
                & ~(raw_q[`ADC_TRIGGER_BIT] & cfg_q.irq_mask[`ADC_TRIGGER_BIT]);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dir_q <= `RST_ZERO;
      alt_q <= ALT_RESET;
      data_q <= `RST_ZERO;
      raw_q <= `RST_ZERO;
      samp_q <= `RST_ZERO;
      prev_q <= `RST_ZERO;
      cfg_q <= '0;
      pad_q <= {`RST_DRIVE_2MA, `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_PULL_UP,
                `RST_ZERO, `RST_ZERO, `RST_DIGITAL_EN};
      ph_q <= PH_IDLE;
      ofs_q <= 12'h000;
      rdata_q <= 32'h0;
      irq_q <= 1'b0;
      trig_q <= 1'b0;
      pin_out_q <= `RST_ZERO;
      pin_oe_q <= `RST_ZERO;
      pin_in_q <= `RST_ZERO;
    end else begin
      dir_q <= dir_d;
      alt_q <= alt_d;
      data_q <= data_d;
      raw_q <= raw_d;
      samp_q <= samp_d;
      prev_q <= prev_d;
      cfg_q <= cfg_d;
      pad_q <= pad_d;
      ph_q <= ph_d;
      ofs_q <= ofs_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      trig_q <= trig_d;
      pin_out_q <= pin_out_d;
      pin_oe_q <= pin_oe_d;
      pin_in_q <= pin_in_d;
    end
  end

  // Checks on $past values are guarded so a mid-run reset cannot trip them
  chk_irq_from_masked: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> port_irq == |($past(raw_d) & $past(cfg_d.irq_mask)))
    else $error("port interrupt does not follow masked status");

  chk_edge_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    (!cfg_q.irq_sense_select[0] && raw_q[0] && !clr[0] && $stable(cfg_q)) |=> raw_q[0])
    else $error("edge status dropped without clear");

  chk_clear_one: assert property (@(posedge clk) disable iff (!rst_n)
    (!cfg_q.irq_sense_select[1] && clr[1] && !cond[1]) |=> !raw_q[1])
    else $error("write one to clear did not clear");

  chk_rise_sets: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_q.irq_event_polarity[2] && !cfg_q.irq_sense_select[2] && rise[2]) |=> raw_q[2])
    else $error("rising edge not latched");

  chk_level_raw: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_q.irq_sense_select[3] |=> raw_q[3] == ($past(cfg_q.irq_event_polarity[3]) ~^ $past(samp_q[3])))
    else $error("level status wrong");

  chk_input_tracks: assert property (@(posedge clk) disable iff (!rst_n)
    (!dir_q[5] && !wr) |=> data_q[5] == $past(samp_q[5]))
    else $error("input bit not captured");

  chk_write_masked: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && ofs_q < 12'h400 && !ofs_q[8]) |=> $stable(data_q[6]) || !$past(dir_q[6]))
    else $error("masked data bit changed");

  chk_read_masked: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_take && haddr[11:0] < 12'h400 && !haddr[2]) |=> hrdata[0] == 1'b0)
    else $error("masked read bit not zero");

  chk_pin_drive: assert property (@(posedge clk) disable iff (!rst_n)
    ($past(rst_n) && $past(!alt_d[7]) && $past(dir_d[7])) |-> (pin_oe[7] && pin_out[7] == data_q[7]))
    else $error("output pin not driven from data");

  chk_adc_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    adc_trigger |-> (raw_q[`ADC_TRIGGER_BIT] && cfg_q.irq_mask[`ADC_TRIGGER_BIT]))
    else $error("adc trigger without unmasked condition");

  chk_masked_status: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_take && haddr[11:0] == `OFS_IRQ_MASKED) |=> hrdata[7:0] == ($past(raw_q) & $past(cfg_q.irq_mask)))
    else $error("masked status read wrong");

  chk_raw_read: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_take && haddr[11:0] == `OFS_IRQ_RAW) |=> hrdata[7:0] == $past(raw_q))
    else $error("raw status read wrong");

  chk_read_upper: assert property (@(posedge clk) disable iff (!rst_n)
    rd_take |=> hrdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");

  chk_data_read: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_take && haddr[11:0] < 12'h400) |=> hrdata[7:0] == ($past(data_q) & $past(haddr[9:2])))
    else $error("data read not masked by address");

  chk_dir_write: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && ofs_q == `OFS_DIRECTION) |=> dir_q == $past(wbyte))
    else $error("direction write lost");

  // Reset values checked without a disable, since reset is the antecedent
  chk_alt_reset: assert property (@(posedge clk)
    !rst_n |=> (alt_q == ALT_RESET && dir_q == 8'h00))
    else $error("direction or alternate select not at reset value");

  chk_pins_reset: assert property (@(posedge clk)
    !rst_n |=> (pin_oe == 8'h00 && !port_irq && !adc_trigger))
    else $error("pin or interrupt outputs not cleared by reset");

  chk_alt_pin: assert property (@(posedge clk) disable iff (!rst_n)
    ($past(rst_n) && $past(alt_d[7])) |-> (pin_out[7] == $past(periph_out[7]) && pin_oe[7] == $past(periph_oe[7])))
    else $error("peripheral does not own its pin");

  chk_irq_all_masked: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_q.irq_mask == 8'h00 && !wr) |=> !port_irq)
    else $error("interrupt passed a closed mask");

  chk_trig_single: assert property (@(posedge clk) disable iff (!rst_n)
    adc_trigger |=> !adc_trigger)
    else $error("adc trigger longer than one cycle");

  chk_both_edges: assert property (@(posedge clk) disable iff (!rst_n)
    (!cfg_q.irq_sense_select[4] && cfg_q.irq_both_edges[4] && (rise[4] || fall[4])) |=> raw_q[4])
    else $error("edge missed in both-edge mode");

  chk_fall_sets: assert property (@(posedge clk) disable iff (!rst_n)
    (!cfg_q.irq_sense_select[1] && !cfg_q.irq_both_edges[1] && !cfg_q.irq_event_polarity[1] && fall[1]) |=> raw_q[1])
    else $error("falling edge not latched");

  chk_clear_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && ofs_q == `OFS_IRQ_CLEAR && !hwdata[2] && !cfg_q.irq_sense_select[2] && raw_q[2]) |=> raw_q[2])
    else $error("writing zero cleared a pending edge");

  chk_pad_write: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && ofs_q == `OFS_PULL_UP) |=> pad_ctrl.pull_up_select == $past(wbyte))
    else $error("pad setting not presented");

  chk_unconnected: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && ofs_q == `OFS_DIRECTION) |=> (dir_q & ~PIN_CONNECTED) == 8'h00)
    else $error("unconnected bit took a write");

  chk_id_read: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_take && haddr[11:0] >= `OFS_ID_FIRST) |=> hrdata[7:0] == ID_BYTES[8*$past(id_idx) +: 8])
    else $error("identification value wrong");

  chk_irq_has_source: assert property (@(posedge clk) disable iff (!rst_n)
    port_irq |-> |(raw_q & cfg_q.irq_mask))
    else $error("port interrupt without masked source");

  chk_level_no_latch: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_q.irq_sense_select[6] && cfg_q.irq_event_polarity[6] && !samp_q[6]) |=> !raw_q[6])
    else $error("level status held after level went away");

  chk_oe_from_dir: assert property (@(posedge clk) disable iff (!rst_n)
    ($past(rst_n) && !$past(alt_d[2])) |-> pin_oe[2] == $past(dir_d[2]))
    else $error("pin enable does not follow direction");
endmodule

// ===== rtl/gpio_port_params.svh
`ifndef GPIO_PORT_PARAMS_SVH
`define GPIO_PORT_PARAMS_SVH
`define PIN_COUNT 8
`define OFS_DATA_LAST 12'h3fc
`define OFS_DIRECTION 12'h400
`define OFS_IRQ_SENSE 12'h404
`define OFS_IRQ_BOTH 12'h408
`define OFS_IRQ_EVENT 12'h40c
`define OFS_IRQ_MASK 12'h410
`define OFS_IRQ_RAW 12'h414
`define OFS_IRQ_MASKED 12'h418
`define OFS_IRQ_CLEAR 12'h41c
`define OFS_ALT_FUNC 12'h420
`define OFS_DRIVE_2MA 12'h500
`define OFS_DRIVE_4MA 12'h504
`define OFS_DRIVE_8MA 12'h508
`define OFS_OPEN_DRAIN 12'h50c
`define OFS_PULL_UP 12'h510
`define OFS_PULL_DOWN 12'h514
`define OFS_SLEW 12'h518
`define OFS_DIGITAL_EN 12'h51c
`define OFS_ID_FIRST 12'hfd0
`define MASK_ADDR_LSB 2
`define ADC_TRIGGER_BIT 4
`define RST_DRIVE_2MA 8'hff
`define RST_PULL_UP 8'hff
`define RST_DIGITAL_EN 8'hff
`define RST_ZERO 8'h00
`endif

// ===== rtl/gpio_port_pkg.sv
package gpio_port_pkg;
  typedef struct packed {
    logic [7:0] drive_2ma_select;
    logic [7:0] drive_4ma_select;
    logic [7:0] drive_8ma_select;
    logic [7:0] open_drain_select;
    logic [7:0] pull_up_select;
    logic [7:0] pull_down_select;
    logic [7:0] slew_rate_select;
    logic [7:0] digital_enable;
  } pad_ctrl_s;
  typedef struct packed {
    logic [7:0] irq_sense_select;
    logic [7:0] irq_both_edges;
    logic [7:0] irq_event_polarity;
    logic [7:0] irq_mask;
  } irq_cfg_s;
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WRITE = 2'b01,
    PH_READ = 2'b10
  } phase_e;
endpackage

// ===== tb/gpio_pin_partner.sv
`timescale 1ns/1ps
module gpio_pin_partner (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] ext,
  output logic [7:0] pin_in
);
  // Driven pins read back their own level; released pins follow the outside world
  // The outside level is held steady by the bench while a level condition is pending
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule

// ===== tb/gpio_port_with_interrupts_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fails++; \
  $display("ERROR %0t: got %h want %h", $time, a, e); end end
module gpio_port_with_interrupts_tb
  import gpio_port_pkg::*;
;
  logic clk, rst_n, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, port_irq, adc_trigger;
  logic [7:0] pin_in, pin_out, pin_oe, periph_out, periph_oe, ext, adc_cnt, periph_in;
  pad_ctrl_s pad_ctrl;
  int fails, cmp_count, cycles;

  gpio_port #(.ALT_RESET(8'h80)) u_gpio_port (.clk(clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .periph_out(periph_out),
    .periph_oe(periph_oe), .periph_in(periph_in), .pad_ctrl(pad_ctrl), .port_irq(port_irq),
    .adc_trigger(adc_trigger));
  gpio_pin_partner u_gpio_pin_partner (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext),
    .pin_in(pin_in));

  always #5 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (adc_trigger === 1'b1)
      adc_cnt <= adc_cnt + 8'h01;
    if (cycles == 5000) begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("Compared %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Master holds each phase until it sees hready high at an edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rv, e)
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ext = 8'h00;
    periph_out = 8'h80;
    periph_oe = 8'h80;
    adc_cnt = 8'h00;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    // Settling gap before first access, as after a clock enable
    repeat (3) @(posedge clk);
    rd(12'h420, 32'h80);
    rd(12'h400, 32'h0);
    rd(12'h500, 32'hff);
    rd(12'h600, 32'h0);
    rd(12'hfd0, 32'h0);
    rd(12'hffc, 32'h0);
    `CHK(hresp, 1'b0)
    `CHK(pad_ctrl, 64'hff000000_ff0000ff)
    wr(12'h50c, 32'h0f);
    @(posedge clk);
    `CHK(pad_ctrl.open_drain_select, 8'h0f)
    $display("test reset_and_pads done");
    wr(12'h400, 32'hff);
    wr(12'h098, 32'heb);
    rd(12'h1fc, 32'h22);
    rd(12'h0c4, 32'h20);
    @(posedge clk);
    `CHK(pin_out, 8'ha2)
    `CHK(pin_oe, 8'hff)
    // Pin 7 is owned by its peripheral, so bit 7 stays out of the mask
    ext <= 8'h50;
    wr(12'h400, 32'h0f);
    // Released pins need two sampling edges before the data bits follow
    repeat (3) @(posedge clk);
    rd(12'h1fc, 32'h52);
    `CHK(periph_in, pin_in)
    wr(12'h1fc, 32'hff);
    rd(12'h1fc, 32'h5f);
    $display("test data_mask done");
    wr(12'h410, 32'h0);
    wr(12'h404, 32'h0);
    wr(12'h408, 32'h0);
    wr(12'h40c, 32'h10);
    wr(12'h41c, 32'hff);
    wr(12'h410, 32'h10);
    ext <= 8'h40;
    repeat (5) @(posedge clk);
    ext <= 8'h50;
    repeat (5) @(posedge clk);
    `CHK(port_irq, 1'b1)
    `CHK(adc_cnt, 8'h01)
    rd(12'h414, 32'h10);
    rd(12'h418, 32'h10);
    wr(12'h41c, 32'h0);
    rd(12'h414, 32'h10);
    wr(12'h41c, 32'h10);
    rd(12'h414, 32'h0);
    `CHK(port_irq, 1'b0)
    wr(12'h410, 32'h0);
    wr(12'h408, 32'h10);
    wr(12'h41c, 32'hff);
    ext <= 8'h40;
    repeat (5) @(posedge clk);
    rd(12'h414, 32'h10);
    rd(12'h418, 32'h0);
    // Low level held on bit 4 from here on
    wr(12'h404, 32'h10);
    wr(12'h40c, 32'h0);
    wr(12'h41c, 32'h10);
    rd(12'h414, 32'h10);
    `CHK(port_irq, 1'b0)
    `CHK(adc_cnt, 8'h01)
    $display("test interrupts done");
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(12'h400, 32'h0);
    rd(12'h420, 32'h80);
    $display("test second_reset done");
    tally_and_finish();
  end
endmodule
